// *** hdl/flu_device.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flu_regs.svh"
module flu_device
	import flu_pkg::*;
#(
	parameter int          TICK_CYC = `FLU_CLK_HZ / 1000 * `FLU_TICK_MS,
	parameter logic [15:0] MAX_PKTS = 16'h1000,
	// Product code value is arbitrary
	parameter logic [87:0] PROD_CODE = 88'h0a_09_08_07_06_05_04_03_02_01_00,
	parameter int          FIFO_DEPTH = 8
)(
	input  wire logic        ref_clk_in,     // 20 MHz clock
	input  wire logic        rst_n_in,       // Async reset
	flu_link_if.dev          link,           // Link to host
	input  wire logic        trig_in,        // Recorder trigger
	input  wire logic [7:0]  snap_status_in, // Status to record
	input  wire logic [7:0]  snap_alarm_in,  // Alarms to record
	input  wire logic [15:0] meas_in,        // Measurement
	input  wire logic [1:0]  load_in,        // Load range
	input  wire logic        sec_ok_in,      // Secondary data ok
	input  wire logic        downstream_in,  // Manages downstream
	output logic             app_run_out,    // Application runs
	output logic [7:0]       status_out      // Status byte
);
	// ==========================================
	// Incoming bytes through the FIFO
	logic        f_valid;
	logic [8:0]  f_word;
	logic        resp_act;
	wire logic   f_ready = !resp_act;
	flu_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_in       (ref_clk_in),
		.rst_n_in     (rst_n_in),
		.in_valid_in  (link.h2d_valid),
		.in_data_in   ({link.h2d_last, link.h2d_data}),
		.in_ready_out (link.h2d_ready),
		.out_valid_out(f_valid),
		.out_data_out (f_word),
		.out_ready_in (f_ready)
	);
	// ==========================================
	// Command decode
	logic [2:0]  widx;
	logic [7:0]  cmd;
	logic [7:0]  seq_lo_rx;
	logic [15:0] seq;
	logic [7:0]  st;
	logic [15:0] crc;
	logic [7:0]  d_old;
	logic [7:0]  d_new;
	logic [1:0]  icnt;
	logic        vld;
	logic        app;
	wire logic   take = f_valid && f_ready;
	wire logic [7:0] fd = f_word[7:0];
	wire logic   fl = f_word[8];
	wire logic [15:0] rx_seq = {fd, seq_lo_rx};
	wire logic   seq_hdr = take && widx == 3'd3 && cmd == `FLU_CMD_XFER;
	wire logic   seq_rst = seq_hdr && rx_seq == 16'h0000;
	wire logic   seq_bad = seq_hdr && rx_seq != seq && !seq_rst;
	wire logic   addr_bad = seq_hdr && rx_seq >= MAX_PKTS;
	wire logic   img_b = take && widx == 3'd4 && cmd == `FLU_CMD_XFER;
	wire logic   pkt_end = img_b && fl;
	wire logic   cmd_end = take && fl && widx != 3'd0;
	wire logic   done_ev = cmd_end && cmd == `FLU_CMD_DONE;
	wire logic   exit_ev = cmd_end && cmd == `FLU_CMD_EXIT;
	wire logic   crc_ok = icnt == 2'd2 && crc == {d_old, d_new};
	wire logic   no_err = st[`FLU_ST_ADDR:`FLU_ST_ERASED] == 4'h0;
	assign status_out = st;
	assign app_run_out = app;
	// Byte position within the write phase, saturating at data
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			widx <= 3'd0;
			cmd <= 8'h00;
			seq_lo_rx <= 8'h00;
		end else if (take) begin
			widx <= fl ? 3'd0 : (widx == 3'd4 ? widx : widx + 3'd1);
			if (widx == 3'd0) cmd <= fd;
			if (widx == 3'd2) seq_lo_rx <= fd;
		end
	end
	// Packet count: count zero restarts the whole download
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) seq <= 16'h0000;
		else if (seq_rst) seq <= 16'h0000;
		else if (pkt_end) seq <= seq + 16'h0001;
	end
	// Running CRC-16 lags two bytes so the trailer stays out
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			crc <= `FLU_CRC16_INIT;
			icnt <= 2'd0;
			d_old <= 8'h00;
			d_new <= 8'h00;
		end else if (seq_rst) begin
			crc <= `FLU_CRC16_INIT;
			icnt <= 2'd0;
		end else if (img_b) begin
			if (icnt == 2'd2) crc <= flu_crc16(crc, d_old);
			else icnt <= icnt + 2'd1;
			d_old <= d_new;
			d_new <= fd;
		end
	end
	// Status flags; a set always beats a clear
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= `FLU_ST_RESET;
			vld <= 1'b0;
			app <= 1'b0;
		end else begin
			if (seq_rst) st[`FLU_ST_ERASED] <= 1'b1;
			else if (done_ev && crc_ok) st[`FLU_ST_ERASED] <= 1'b0;
			if (done_ev && !crc_ok) st[`FLU_ST_CRC] <= 1'b1;
			else if (seq_rst || done_ev) st[`FLU_ST_CRC] <= 1'b0;
			if (seq_bad) st[`FLU_ST_SEQ] <= 1'b1;
			else if (seq_rst) st[`FLU_ST_SEQ] <= 1'b0;
			if (addr_bad) st[`FLU_ST_ADDR] <= 1'b1;
			else if (seq_rst) st[`FLU_ST_ADDR] <= 1'b0;
			st[5:4] <= 2'b00;
			st[`FLU_ST_DOWN] <= downstream_in;
			st[`FLU_ST_BOOT] <= !app;
			if (seq_rst) vld <= 1'b0;
			else if (done_ev) vld <= crc_ok;
			if (exit_ev && vld && no_err) app <= 1'b1;
		end
	end
	// ==========================================
	// Recorder, time base and usage buckets
	logic [31:0] tcnt;
	logic        ms_tick;
	logic [31:0] stamp;
	logic [2:0]  wslot;
	logic [1:0]  load_q;
	logic [63:0] rec [0:`FLU_REC_NUM-1];
	logic [15:0] ucnt [0:3];
	logic [15:0] udur [0:3];
	// Millisecond enable drives timestamps and durations
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tcnt <= 32'h0;
			ms_tick <= 1'b0;
			stamp <= 32'h0;
		end else begin
			ms_tick <= tcnt == 32'(TICK_CYC - 1);
			tcnt <= (tcnt == 32'(TICK_CYC - 1)) ? 32'h0 : tcnt + 32'h1;
			if (ms_tick) stamp <= stamp + 32'h1;
		end
	end
	// Flops stand in for the nonvolatile store; reset clears it
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < `FLU_REC_NUM; i++) rec[i] <= 64'h0;
			wslot <= 3'd0;
		end else if (trig_in) begin
			rec[wslot] <= {stamp, meas_in, snap_alarm_in,
				snap_status_in};
			wslot <= (wslot == 3'(`FLU_REC_NUM - 1)) ? 3'd0
				: wslot + 3'd1;
		end
	end
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) load_q <= 2'd0;
		else load_q <= load_in;
	end
	// Entries counted on change of range, time in milliseconds
	for (genvar b = 0; b < 4; b++) begin : g_bkt
		wire logic here = load_in == 2'(b);
		always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				ucnt[b] <= 16'h0;
				udur[b] <= 16'h0;
			end else begin
				if (here && load_q != 2'(b))
					ucnt[b] <= ucnt[b] + 16'h1;
				if (here && ms_tick) udur[b] <= udur[b] + 16'h1;
			end
		end
	end
	// ==========================================
	// Response builder
	logic [11:0] ridx;
	logic [7:0]  pec;
	logic        log_ok;
	logic        served;
	logic        dv;
	logic [7:0]  dd;
	logic        dl;
	wire logic [10:0] la = 11'(ridx - 12'd2);
	wire logic [5:0]  row = la[10:5];
	wire logic [4:0]  col = la[4:0];
	wire logic [63:0] rrec = rec[row[2:0]];
	wire logic [63:0] rsh = rrec >> {col[2:0], 3'b000};
	wire logic [15:0] bw = col[3] ? udur[col[2:1]] : ucnt[col[2:1]];
	wire logic [7:0]  bkt_b = (col[4] == 1'b0) ? (col[0] ? bw[15:8]
		: bw[7:0]) : (col == `FLU_SLOT_COL) ? {5'h00, wslot} : 8'h00;
	wire logic [7:0]  arr_b = (row < 6'(`FLU_REC_NUM)) ? (col[4:3] == 2'b00
		? rsh[7:0] : 8'h00) : (row == `FLU_BKT_ROW) ? bkt_b : 8'h00;
	wire logic [7:0]  log_b = !log_ok ? 8'h00 : (ridx == 12'd0)
		? `FLU_LOG_LEN_LO : (ridx == 12'd1) ? `FLU_LOG_LEN_HI : arr_b;
	wire logic [87:0] psh = PROD_CODE >> {ridx[3:0] - 4'd1, 3'b000};
	wire logic [7:0]  prod_b = (ridx == 12'd0) ? `FLU_PROD_LEN : psh[7:0];
	wire logic [7:0]  xfer_b = (ridx == 12'd0) ? seq[7:0]
		: (ridx == 12'd1) ? seq[15:8] : st;
	wire logic [7:0]  body = (cmd == `FLU_CMD_XFER) ? xfer_b
		: (cmd == `FLU_CMD_STAT) ? st
		: (cmd == `FLU_CMD_MODE) ? (app ? `FLU_ST_APP : st)
		: (cmd == `FLU_CMD_PROD) ? prod_b
		: (cmd == `FLU_CMD_LOG) ? log_b : 8'h00;
	wire logic [11:0] rlen = (cmd == `FLU_CMD_XFER) ? `FLU_XFER_LEN
		: (cmd == `FLU_CMD_STAT || cmd == `FLU_CMD_MODE) ? 12'd1
		: (cmd == `FLU_CMD_PROD) ? `FLU_PROD_RLEN
		: (cmd == `FLU_CMD_LOG) ? (log_ok ? `FLU_LOG_RLEN : 12'd1)
		: 12'd0;
	wire logic   start = link.rd_req && !resp_act && !served && !f_valid;
	wire logic   hs = dv && link.d2h_ready;
	assign link.d2h_valid = dv;
	assign link.d2h_data = dd;
	assign link.d2h_last = dl;
	// One byte in flight at a time; the PEC always closes it
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			resp_act <= 1'b0;
			served <= 1'b0;
			log_ok <= 1'b0;
			ridx <= 12'd0;
			pec <= 8'h00;
			dv <= 1'b0;
			dd <= 8'h00;
			dl <= 1'b0;
		end else begin
			if (!link.rd_req) served <= 1'b0;
			if (start) begin
				resp_act <= 1'b1;
				log_ok <= sec_ok_in;
				ridx <= 12'd0;
				pec <= 8'h00;
			end else if (resp_act && !dv && !dl) begin
				dv <= 1'b1;
				dl <= ridx == rlen;
				dd <= (ridx == rlen) ? pec : body;
				pec <= flu_pec(pec, body);
				ridx <= ridx + 12'd1;
			end else if (hs) begin
				dv <= 1'b0;
			end else if (resp_act && !dv && dl) begin
				dl <= 1'b0;
				resp_act <= 1'b0;
				served <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** hdl/flu_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module flu_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
)(
	input  wire logic             clk_in,        // Clock
	input  wire logic             rst_n_in,      // Async reset
	input  wire logic             in_valid_in,   // Write valid
	input  wire logic [WIDTH-1:0] in_data_in,    // Write word
	output logic                  in_ready_out,  // Not full
	output logic                  out_valid_out, // Not empty
	output logic      [WIDTH-1:0] out_data_out,  // Head word
	input  wire logic             out_ready_in   // Pop
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0]    wp;
	logic [AW-1:0]    rp;
	logic [AW:0]      cnt;
	wire logic        push = in_valid_in && in_ready_out;
	wire logic        pop = out_valid_out && out_ready_in;
	wire logic [AW:0] next_cnt = cnt + {{AW{1'b0}}, push}
		- {{AW{1'b0}}, pop};
	// Depth must be a power of two so the pointers wrap freely
	assign out_data_out = mem[rp];
	always_ff @(posedge clk_in) begin
		if (push) mem[wp] <= in_data_in;
	end
	// Flags are registered so in_ready_out and out_valid_out come from flip-flops
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
			in_ready_out <= 1'b1;
			out_valid_out <= 1'b0;
		end else begin
			if (push) wp <= wp + 1'b1;
			if (pop) rp <= rp + 1'b1;
			cnt <= next_cnt;
			in_ready_out <= next_cnt != (AW+1)'(DEPTH);
			out_valid_out <= next_cnt != '0;
		end
	end
endmodule
`default_nettype wire

// *** hdl/flu_host.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "flu_regs.svh"
module flu_host
	import flu_pkg::*;
#(
	parameter int PKT_BYTES = 16,
	parameter int SEQ_WAIT = `FLU_SEQ_WAIT_MS * (`FLU_CLK_HZ / 1000),
	parameter int CHK_WAIT = `FLU_CHK_WAIT_MS * (`FLU_CLK_HZ / 1000),
	parameter int LOG_WAIT = `FLU_LOG_WAIT_MS * (`FLU_CLK_HZ / 1000)
)(
	input  wire logic       ref_clk_in,    // 20 MHz clock
	input  wire logic       rst_n_in,      // Async reset
	flu_link_if.host        link,          // Link to device
	input  wire logic       start_in,      // Start upgrade
	input  wire logic [2:0] tgt_en_in,     // Targets p, s, i
	input  wire logic       img_valid_in,  // Image byte valid
	input  wire logic [7:0] img_data_in,   // Image byte
	input  wire logic       img_last_in,   // Last of target image
	output logic            img_ready_out, // Byte taken pulse
	input  wire logic       log_start_in,  // Start log upload
	output logic            busy_out,      // Sequence running
	output logic            done_out,      // Upgrade done pulse
	output logic            err_out,       // Aborted on error
	output logic            log_valid_out, // Log byte pulse
	output logic [7:0]      log_data_out   // Log byte
);
	// ==========================================
	// Sequencer state
	flu_hstate_t st;
	flu_phase_t  ph;
	logic [2:0]  pend;
	logic [1:0]  ti;
	logic [15:0] seq;
	logic        imgend;
	logic [7:0]  idx;
	logic [31:0] wcnt;
	logic [7:0]  rb [0:2];
	logic [7:0]  pec;
	logic        pec_ok;
	logic [11:0] ridx;
	logic        tv;
	logic [7:0]  td;
	logic        tl;
	logic        rq;
	logic        rr;
	assign link.h2d_valid = tv;
	assign link.h2d_data = td;
	assign link.h2d_last = tl;
	assign link.rd_req = rq;
	assign link.d2h_ready = rr;
	assign busy_out = st != H_IDLE;
	// ==========================================
	// Byte and timing selection
	wire logic [7:0] cmd_b = (ph == P_PKT || ph == P_SEQRD) ? `FLU_CMD_XFER
		: (ph == P_DONE) ? `FLU_CMD_DONE : (ph == P_STAT) ? `FLU_CMD_STAT
		: (ph == P_EXIT) ? `FLU_CMD_EXIT : (ph == P_MODE) ? `FLU_CMD_MODE
		: `FLU_CMD_LOG;
	wire logic [7:0] tch = (ti == 2'd0) ? `FLU_TGT_P
		: (ti == 2'd1) ? `FLU_TGT_S : `FLU_TGT_I;
	wire logic [7:0] hdr_b = (idx == 8'd0) ? cmd_b : (idx == 8'd1) ? tch
		: (idx == 8'd2) ? seq[7:0] : seq[15:8];
	wire logic hdr_end = (ph == P_LOG) ? idx == 8'd0
		: ph != P_PKT && idx == 8'd1;
	wire logic in_data = ph == P_PKT && idx >= 8'd4;
	wire logic pkt_end = img_last_in || idx == 8'(PKT_BYTES + 3);
	wire logic [31:0] wsel = (ph == P_PKT) ? 32'(SEQ_WAIT - 1)
		: (ph == P_LOG) ? 32'(LOG_WAIT - 1) : 32'(CHK_WAIT - 1);
	wire logic waits = ph == P_PKT || ph == P_DONE || ph == P_EXIT
		|| ph == P_LOG;
	wire logic rx = link.d2h_valid && rr;
	wire logic [1:0] pick = pend[0] ? 2'd0 : pend[1] ? 2'd1 : 2'd2;
	wire logic [15:0] rseq = {rb[1], rb[0]};
	// ==========================================
	// Sequencer; a failed upgrade check ends with the error flag set; a bad log PEC does not
	always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st <= H_IDLE; ph <= P_PKT; pend <= 3'b000; ti <= 2'd0;
			seq <= 16'h0; imgend <= 1'b0; idx <= 8'd0; wcnt <= 32'h0;
			rb[0] <= 8'h0; rb[1] <= 8'h0; rb[2] <= 8'h0;
			pec <= 8'h0; pec_ok <= 1'b0; ridx <= 12'd0;
			tv <= 1'b0; td <= 8'h0; tl <= 1'b0; rq <= 1'b0; rr <= 1'b0;
			img_ready_out <= 1'b0; done_out <= 1'b0; err_out <= 1'b0;
			log_valid_out <= 1'b0; log_data_out <= 8'h0;
		end else begin
			img_ready_out <= 1'b0;
			done_out <= 1'b0;
			log_valid_out <= 1'b0;
			case (st)
			H_IDLE: begin
				idx <= 8'd0;
				if (start_in) begin
					pend <= tgt_en_in;
					err_out <= 1'b0;
					st <= H_NEXT;
				end else if (log_start_in) begin
					ph <= P_LOG;
					st <= H_SEND;
				end
			end
			H_NEXT: begin
				if (pend == 3'b000) begin
					done_out <= 1'b1;
					st <= H_IDLE;
				end else begin
					ti <= pick;
					pend[pick] <= 1'b0;
					seq <= 16'h0000;
					imgend <= 1'b0;
					ph <= P_PKT;
					st <= H_SEND;
				end
			end
			H_SEND: begin
				if (tv && link.h2d_ready) begin
					tv <= 1'b0;
					idx <= idx + 8'd1;
					if (tl) begin
						idx <= 8'd0;
						wcnt <= wsel;
						st <= waits ? H_WAIT : H_READ;
					end
				end else if (!tv && in_data) begin
					if (img_valid_in && !img_ready_out) begin
						tv <= 1'b1;
						td <= img_data_in;
						tl <= pkt_end;
						imgend <= img_last_in;
						img_ready_out <= 1'b1;
					end
				end else if (!tv) begin
					tv <= 1'b1;
					td <= hdr_b;
					tl <= hdr_end;
				end
			end
			H_WAIT: begin
				wcnt <= wcnt - 32'h1;
				if (wcnt == 32'h0) begin
					st <= (ph == P_LOG) ? H_READ : H_SEND;
					if (ph == P_PKT) ph <= P_SEQRD;
					if (ph == P_DONE) ph <= P_STAT;
					if (ph == P_EXIT) ph <= P_MODE;
				end
			end
			H_READ: begin
				rq <= 1'b1;
				rr <= 1'b1;
				if (rx) begin
					ridx <= ridx + 12'd1;
					pec <= flu_pec(pec, link.d2h_data);
					if (!link.d2h_last && ridx < 12'd3)
						rb[ridx[1:0]] <= link.d2h_data;
					if (ph == P_LOG && !link.d2h_last) begin
						log_valid_out <= 1'b1;
						log_data_out <= link.d2h_data;
					end
					if (link.d2h_last) begin
						pec_ok <= link.d2h_data == pec;
						rq <= 1'b0;
						rr <= 1'b0;
						ridx <= 12'd0;
						pec <= 8'h0;
						st <= (ph == P_LOG) ? H_IDLE : H_EVAL;
					end
				end
			end
			H_EVAL: begin
				st <= H_IDLE;
				if (!pec_ok) err_out <= 1'b1;
				else if (ph == P_SEQRD) begin
					// Erased bit is normal mid-download; only errors abort
					if (rseq != seq + 16'h1 || rb[2][3:1] != 3'h0)
						err_out <= 1'b1;
					else begin
						seq <= rseq;
						ph <= imgend ? P_DONE : P_PKT;
						st <= H_SEND;
					end
				end else if (ph == P_STAT) begin
					if (rb[0] != `FLU_ST_GOOD) err_out <= 1'b1;
					else begin
						ph <= P_EXIT;
						st <= H_SEND;
					end
				end else if (rb[0] != `FLU_ST_APP) err_out <= 1'b1;
				else st <= H_NEXT;
			end
			default: st <= H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** hdl/flu_link_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface flu_link_if;
	// ==========================================
	// Write phase bytes, read request, read bytes
	logic       h2d_valid;
	logic [7:0] h2d_data;
	logic       h2d_last;
	logic       h2d_ready;
	logic       rd_req;
	logic       d2h_valid;
	logic [7:0] d2h_data;
	logic       d2h_last;
	logic       d2h_ready;
	modport dev (input h2d_valid, h2d_data, h2d_last, rd_req,
		d2h_ready, output h2d_ready, d2h_valid, d2h_data, d2h_last);
	modport host (output h2d_valid, h2d_data, h2d_last, rd_req,
		d2h_ready, input h2d_ready, d2h_valid, d2h_data, d2h_last);
endinterface
`default_nettype wire

// *** hdl/flu_pkg.sv ***
`include "flu_regs.svh"
package flu_pkg;
	// ==========================================
	// Host states and phases
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_NEXT = 3'b001,
		H_SEND = 3'b010,
		H_WAIT = 3'b011,
		H_READ = 3'b100,
		H_EVAL = 3'b101
	} flu_hstate_t;
	typedef enum logic [2:0] {
		P_PKT   = 3'b000,
		P_SEQRD = 3'b001,
		P_DONE  = 3'b010,
		P_STAT  = 3'b011,
		P_EXIT  = 3'b100,
		P_MODE  = 3'b101,
		P_LOG   = 3'b110
	} flu_phase_t;
	// ==========================================
	// One byte step of the PEC (CRC-8)
	function automatic logic [7:0] flu_pec(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ((r << 1) ^ `FLU_PEC_POLY) : (r << 1);
		end
		return r;
	endfunction
	// One byte step of the image check value (CRC-16)
	function automatic logic [15:0] flu_crc16(input logic [15:0] c,
		input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {d, 8'h00};
		for (int i = 0; i < 8; i++) begin
			r = r[15] ? ((r << 1) ^ `FLU_CRC16_POLY) : (r << 1);
		end
		return r;
	endfunction
endpackage

// *** hdl/flu_regs.svh ***
`ifndef FLU_REGS_SVH
`define FLU_REGS_SVH
// ==========================================
// Command codes
`define FLU_CMD_MODE   8'he1
`define FLU_CMD_STAT   8'he5
`define FLU_CMD_XFER   8'he7
`define FLU_CMD_PROD   8'he8
`define FLU_CMD_DONE   8'he9
`define FLU_CMD_EXIT   8'hea
`define FLU_CMD_LOG    8'hf0
// ==========================================
// Status byte fields and values
`define FLU_ST_ERASED  0
`define FLU_ST_CRC     1
`define FLU_ST_SEQ     2
`define FLU_ST_ADDR    3
`define FLU_ST_DOWN    6
`define FLU_ST_BOOT    7
`define FLU_ST_RESET   8'h80
`define FLU_ST_GOOD    8'h80
`define FLU_ST_APP     8'h00
// ==========================================
// Response layout
`define FLU_PROD_LEN   8'h0b
`define FLU_XFER_LEN   12'h003
`define FLU_PROD_RLEN  12'h00c
`define FLU_LOG_RLEN   12'h802
`define FLU_LOG_LEN_LO 8'h00
`define FLU_LOG_LEN_HI 8'h08
`define FLU_REC_NUM    5
`define FLU_BKT_ROW    6'h05
`define FLU_SLOT_COL   5'h10
// ==========================================
// Check value and PEC
`define FLU_CRC16_INIT 16'hffff
`define FLU_CRC16_POLY 16'h1021
`define FLU_PEC_POLY   8'h07
// ==========================================
// Target characters and timing
`define FLU_TGT_P      8'h70
`define FLU_TGT_S      8'h73
`define FLU_TGT_I      8'h69
`define FLU_CLK_HZ     20000000
`define FLU_TICK_MS    1
`define FLU_SEQ_WAIT_MS 150
`define FLU_CHK_WAIT_MS 1000
`define FLU_LOG_WAIT_MS 100
`endif

// *** tb/firmware_upgrade_loader_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module firmware_upgrade_loader_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        start = 1'b0;
	logic        lstart = 1'b0;
	logic        trig = 1'b0;
	logic [7:0]  snap = 8'h00;
	logic [1:0]  load = 2'h0;
	logic        sec_ok = 1'b1;
	logic        bad = 1'b0;
	logic        dn = 1'b0;
	logic        irdy, busy, done, err, app, lv;
	logic [7:0]  st, img, ld;
	logic [2:0]  tgt = 3'b001;
	logic        iv = 1'b0;
	logic        dstr = 1'b0;
	int          lcnt = 0;
	logic [15:0] c;
	logic [7:0]  q [$];
	int          idx = 0;
	int          cyc = 0;
	int          error_cnt = 0;
	int          num_checks = 0;
	flu_link_if lk ();
	// ==========================================
	// Image: eight data bytes then CRC-16 trailer, MSB first
	assign img = idx < 8 ? 8'(8'h10 + idx) : idx == 8 ? c[15:8]
		: c[7:0] ^ {7'h0, bad};
	flu_host #(.PKT_BYTES(4), .SEQ_WAIT(20), .CHK_WAIT(40),
		.LOG_WAIT(10)) i_flu_host (
		.ref_clk_in(clk), .rst_n_in(rst_n), .link(lk.host),
		.start_in(start), .tgt_en_in(tgt), .img_valid_in(iv),
		.img_data_in(img), .img_last_in(idx == 9), .img_ready_out(irdy),
		.log_start_in(lstart), .busy_out(busy), .done_out(done),
		.err_out(err), .log_valid_out(lv), .log_data_out(ld));
	flu_device #(.TICK_CYC(4)) i_flu_device (.ref_clk_in(clk),
		.rst_n_in(rst_n), .link(lk.dev), .trig_in(trig),
		.snap_status_in(snap), .snap_alarm_in(snap),
		.meas_in({snap, snap}), .load_in(load), .sec_ok_in(sec_ok),
		.downstream_in(dstr), .app_run_out(app), .status_out(st));
	flu_link_chk i_flu_link_chk (.ref_clk_in(clk), .rst_n_in(rst_n),
		.h2d_valid(lk.h2d_valid), .h2d_data(lk.h2d_data),
		.h2d_ready(lk.h2d_ready), .rd_req(lk.rd_req),
		.d2h_valid(lk.d2h_valid), .d2h_data(lk.d2h_data),
		.d2h_last(lk.d2h_last), .d2h_ready(lk.d2h_ready));
	// ==========================================
	// Clock, image source, read byte capture, hang guard
	always #25 clk = ~clk;
	always @(posedge clk) begin
		// Image source stalls every other cycle to exercise its valid
		iv <= ~iv;
		if (lv === 1'b1)
			lcnt <= lcnt + 1;
		if (irdy === 1'b1)
			idx <= idx == 9 ? 0 : idx + 1;
		if (done === 1'b1)
			dn <= 1'b1;
		if (lk.d2h_valid && lk.d2h_ready)
			q.push_back(lk.d2h_data);
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// Bitwise CRC of width w; kept apart from the design's own helpers
	function automatic logic [15:0] crc(input logic [15:0] cv, input logic [7:0] d,
		input int w, input logic [15:0] p);
		logic [15:0] r;
		r = cv ^ (16'(d) << (w - 8));
		for (int i = 0; i < 8; i++)
			r = r[w-1] ? ((r << 1) ^ p) : (r << 1);
		return w == 8 ? {8'h00, r[7:0]} : r;
	endfunction
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("[ERR] %0t: got %h want %h", $time, s, e);
		end
	endtask
	// Pulse a start, then wait out the busy level with a bound
	task automatic go(input logic lg);
		@(posedge clk);
		start <= !lg;
		lstart <= lg;
		dn <= 1'b0;
		lcnt <= 0;
		q.delete();
		@(posedge clk);
		start <= 1'b0;
		lstart <= 1'b0;
		repeat (3) @(posedge clk);
		for (int n = 0; n < 9000 && busy !== 1'b0; n++)
			@(posedge clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================
	// Main sequence
	initial begin
		c = 16'hffff;
		for (int i = 0; i < 8; i++)
			c = crc(c, 8'(8'h10 + i), 16, 16'h1021);
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk(16'(st), 16'h80);
		// Six snapshots wrap the five slots once
		for (int k = 0; k < 6; k++) begin
			@(posedge clk);
			trig <= 1'b1;
			snap <= 8'(8'ha0 + k);
			load <= 2'h2;
			@(posedge clk);
			trig <= 1'b0;
		end
		bad <= 1'b1;
		idx <= 0;
		go(1'b0);
		chk(16'(err), 16'h1);
		chk(16'(app), 16'h0);
		chk(16'(st), 16'h83);
		bad <= 1'b0;
		idx <= 0;
		go(1'b0);
		chk(16'(dn), 16'h1);
		chk(16'(err), 16'h0);
		chk(16'(app), 16'h1);
		chk(16'(st), 16'h00);
		chk(16'(q[q.size()-2]), 16'h00);
		go(1'b1);
		chk(16'(q.size()), 16'd2051);
		chk({q[1], q[0]}, 16'h0800);
		chk(16'(q[2]), 16'ha5);
		chk(16'(q[34]), 16'ha1);
		chk(16'(q[166]), 16'h01);
		chk(16'(q[178]), 16'h01);
		chk(16'(lcnt), 16'd2050);
		chk(16'(ld), 16'h00);
		c = 16'h0000;
		for (int i = 0; i < 2050; i++)
			c = crc(c, q[i], 8, 16'h0007);
		chk(16'(q[2050]), c);
		sec_ok <= 1'b0;
		go(1'b1);
		chk({q[1], q[0]}, 16'h0000);
		chk(16'(q.size()), 16'd2);
		chk(16'(lcnt), 16'd1);
		@(posedge clk);
		dstr <= 1'b1;
		repeat (2) @(posedge clk);
		#1 chk(16'(st), 16'h40);
		print_verdict();
	end
endmodule
`default_nettype wire

// *** tb/flu_link_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Link handshake checks, both ends are design
module flu_link_chk (
	input wire logic       ref_clk_in, // Clock
	input wire logic       rst_n_in,   // Reset
	input wire logic       h2d_valid,  // Write valid
	input wire logic [7:0] h2d_data,   // Write byte
	input wire logic       h2d_ready,  // Room
	input wire logic       rd_req,     // Read phase
	input wire logic       d2h_valid,  // Read valid
	input wire logic [7:0] d2h_data,   // Read byte
	input wire logic       d2h_last,   // PEC byte
	input wire logic       d2h_ready   // Host takes
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	// A refused byte must wait unchanged for room
	a_wr_hold: assert property (h2d_valid && !h2d_ready |=>
		h2d_valid && $stable(h2d_data)) else $error("write byte dropped");
	a_rd_hold: assert property (d2h_valid && !d2h_ready |=>
		d2h_valid && $stable(d2h_data)) else $error("read byte dropped");
	a_byte_gap: assert property (d2h_valid && d2h_ready |=>
		!d2h_valid) else $error("no gap after byte");
	// PEC closes the read; two idle cycles follow
	a_pec_close: assert property (d2h_valid && d2h_ready && d2h_last
		|=> !d2h_valid [*2]) else $error("bytes after PEC");
	a_rd_only: assert property (d2h_valid |-> rd_req)
		else $error("byte without read");
	a_rd_late: assert property ($rose(rd_req) |-> !d2h_valid)
		else $error("answer too early");
	a_rd_answer: assert property ($rose(rd_req) |-> ##[1:300] d2h_valid)
		else $error("read never answered");
	a_req_kept: assert property (rd_req && !(d2h_valid && d2h_ready
		&& d2h_last) |=> rd_req) else $error("read dropped early");
endmodule
`default_nettype wire
